/* src/cbm_mode_ctrl.sv */
// Charger mode control, host watchdog, charge timer and boost start-up sequencer.
// Assumes analog flags and pins are asynchronous and an Avalon-MM master on i_clk.
`timescale 1ns/10ps
// Operation
// - Setting high-z or charge disable stops charging and clears watchdog; only high-z enters high-z.
// - Watchdog runs in high-z with weak battery; overflow resets registers.
// - Charge timer overflow sets charge disable; a host write or a watchdog expiry with weak battery clears it.
// - Reset bit defaults registers; from high-z or charge disable device holds high-z, watchdog not started.
// - Charge only when pin, disable and high-z are low; pin freezes watchdog.
// - Disable pin rising during timed charging clears the charge timer.
// - Mode decoded from high-z, boost select and fault state.
// - Boost select clears whenever boost turns off.
// - Boost only in watchdog mode; OTG pin active level follows polarity bit.
// - OTG pin starts boost despite high-z; boost select needs high-z low.
// - Watchdog expiry in boost resets registers, pulses status, fault code 110.
// - Output above reference after off-time enters pulse skipping, longer on-time.
// - Precharge mid rail; fault if not in range within 560 us.
// - Soft-start at half limit; near set point closes loop, full limit.
// - Full limit after 128 us; fault if still low after further 384 us.
// - In regulate state switch stays off while feedback exceeds reference.
// - Minimum on-time lengthened after zero current in previous cycle.
// - Boost fault pulses status, clears select, high-z stage, writes code.
// - Register-started boost stays off after fault until host commands.
// - OTG-started boost retries 5.2 ms after fault, then every 5 ms.
// - Fault codes 000,001,010,011,101,110; 100 and 111 never produced.
module cbm_mode_ctrl #(
  parameter longint unsigned WDOG_CYC = cbm_pkg::WDOG_CYC,
  parameter longint unsigned CHG_TMR_CYC = cbm_pkg::CHG_TMR_CYC,
  parameter int unsigned RESTART_FIRST_CYC = cbm_pkg::RESTART_FIRST_CYC,
  parameter int unsigned RESTART_NEXT_CYC = cbm_pkg::RESTART_NEXT_CYC,
  parameter int unsigned LIN_TMO_CYC = cbm_pkg::LIN_TMO_CYC,
  parameter int unsigned SS_HALF_CYC = cbm_pkg::SS_HALF_CYC,
  parameter int unsigned SS_FULL_CYC = cbm_pkg::SS_FULL_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_disable_pin,
  input wire logic i_otg_pin,
  input wire logic i_bus_por,
  input wire cbm_pkg::cbm_analog_t i_analog,
  output logic o_charge_en,
  output logic o_status_pulse,
  output cbm_pkg::cbm_mode_t o_mode,
  output cbm_pkg::cbm_boost_ctl_t o_boost_ctl
);
  typedef enum logic [2:0] {
    ST_OFF,
    ST_PRECHARGE,
    ST_SOFTSTART,
    ST_REGULATE,
    ST_FAULT_WAIT
  } cbm_bst_state_t;

  localparam int AW = $bits(cbm_pkg::cbm_analog_t);

  logic [AW-1:0] an_s1_ff;
  logic [AW-1:0] an_s2_ff;
  logic [2:0] pin_s1_ff;
  logic [2:0] pin_s2_ff;
  cbm_pkg::cbm_analog_t an;
  logic dis_pin;
  logic otg_raw;
  logic por;
  logic dis_pin_d_ff;

  logic high_z_request_ff;
  logic boost_select_bit_ff;
  logic charge_disable_bit_ff;
  logic otg_pin_enable_ff;
  logic otg_pin_polarity_ff;
  logic hz_hold_ff;
  logic [2:0] fault_code_ff;
  logic fault_active_ff;
  logic timed_charge_ff;
  logic ack_ff;
  logic [63:0] wdog_cnt_ff;
  logic [63:0] chg_cnt_ff;
  logic [31:0] seq_cnt_ff;
  logic [31:0] pulse_cnt_ff;
  logic [31:0] ilim_cnt_ff;
  logic half_done_ff;
  logic skip_ff;
  logic long_on_ff;
  logic otg_started_ff;
  logic retried_ff;
  cbm_bst_state_t state_ff;

  logic wr_ctrl;
  logic rd_status;
  logic otg_active;
  logic boost_req;
  logic wdog_expire;
  logic chg_expire;
  logic sw_reset;
  logic boost_fault;
  logic [2:0] nxt_fault;
  logic boost_on;
  logic charging;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      an_s1_ff <= '0;
      an_s2_ff <= '0;
      pin_s1_ff <= 3'h0;
      pin_s2_ff <= 3'h0;
    end else if (i_ce) begin
      an_s1_ff <= i_analog;
      an_s2_ff <= an_s1_ff;
      pin_s1_ff <= {i_bus_por, i_otg_pin, i_disable_pin};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  assign an = cbm_pkg::cbm_analog_t'(an_s2_ff);
  assign dis_pin = pin_s2_ff[0];
  assign otg_raw = pin_s2_ff[1];
  assign por = pin_s2_ff[2];

  // Bus slave answers every access one cycle after it arrives.
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_ff;
  assign wr_ctrl = i_avs_write & ack_ff & (i_avs_address == cbm_pkg::OFS_CTRL);
  assign rd_status = i_avs_read & ack_ff & (i_avs_address == cbm_pkg::OFS_STATUS);
  assign sw_reset = wr_ctrl & i_avs_writedata[cbm_pkg::CTRL_RESET];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_ff <= 1'b0;
      o_avs_readdata <= 32'h0;
    end else if (i_ce) begin
      ack_ff <= (i_avs_read | i_avs_write) & ~ack_ff;
      if (i_avs_read & ~ack_ff) begin
        unique case (i_avs_address)
          cbm_pkg::OFS_STATUS: o_avs_readdata <= {28'h0, fault_active_ff, fault_code_ff};
          cbm_pkg::OFS_CTRL: o_avs_readdata <= {27'h0, otg_pin_polarity_ff,
            otg_pin_enable_ff, charge_disable_bit_ff, high_z_request_ff,
            boost_select_bit_ff};
          cbm_pkg::OFS_MODE: o_avs_readdata <= {26'h0, state_ff, o_mode, o_charge_en};
          default: o_avs_readdata <= 32'h0;
        endcase
      end
    end
  end

  assign otg_active = otg_pin_polarity_ff ? otg_raw : ~otg_raw;
  assign boost_req = (otg_pin_enable_ff & otg_active) |
                     (boost_select_bit_ff & ~high_z_request_ff);
  assign wdog_expire = (wdog_cnt_ff >= WDOG_CYC - 1);
  assign chg_expire = timed_charge_ff & (chg_cnt_ff >= CHG_TMR_CYC - 1);
  assign boost_on = (state_ff != ST_OFF) & (state_ff != ST_FAULT_WAIT);
  assign charging = ~dis_pin & ~charge_disable_bit_ff & ~high_z_request_ff & ~hz_hold_ff &
                    ~boost_on;

  always_comb begin
    nxt_fault = cbm_pkg::FLT_NONE;
    boost_fault = 1'b0;
    if (boost_on) begin
      if (wdog_expire) begin
        nxt_fault = cbm_pkg::FLT_TIMER;
      end else if (an.thermal) begin
        nxt_fault = cbm_pkg::FLT_THERM;
      end else if (an.ovp) begin
        nxt_fault = cbm_pkg::FLT_OVP;
      end else if (~an.batt_above_uvlo) begin
        nxt_fault = cbm_pkg::FLT_UVLO;
      end else if ((state_ff == ST_PRECHARGE && seq_cnt_ff >= LIN_TMO_CYC - 1) ||
                   (state_ff == ST_SOFTSTART && half_done_ff &&
                    seq_cnt_ff >= SS_FULL_CYC - 1) ||
                   (state_ff == ST_REGULATE && ilim_cnt_ff >= cbm_pkg::ILIM_CYC - 1)) begin
        nxt_fault = cbm_pkg::FLT_START;
      end
      boost_fault = (nxt_fault != cbm_pkg::FLT_NONE);
    end
  end

  // Host control bits.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      high_z_request_ff <= 1'b0;
      boost_select_bit_ff <= 1'b0;
      charge_disable_bit_ff <= 1'b0;
      otg_pin_enable_ff <= 1'b0;
      otg_pin_polarity_ff <= 1'b0;
      hz_hold_ff <= 1'b0;
    end else if (i_ce) begin
      if (sw_reset || (wdog_expire && (boost_on || high_z_request_ff ||
          charge_disable_bit_ff))) begin
        high_z_request_ff <= 1'b0;
        hz_hold_ff <= sw_reset & (high_z_request_ff | charge_disable_bit_ff);
        boost_select_bit_ff <= 1'b0;
        charge_disable_bit_ff <= 1'b0;
        otg_pin_enable_ff <= 1'b0;
        otg_pin_polarity_ff <= 1'b0;
      end else if (wr_ctrl) begin
        hz_hold_ff <= 1'b0;
        high_z_request_ff <= i_avs_writedata[cbm_pkg::CTRL_HIGHZ];
        boost_select_bit_ff <= i_avs_writedata[cbm_pkg::CTRL_BOOST_SEL] &
                               ~i_avs_writedata[cbm_pkg::CTRL_HIGHZ];
        charge_disable_bit_ff <= i_avs_writedata[cbm_pkg::CTRL_CHG_DIS];
        otg_pin_enable_ff <= i_avs_writedata[cbm_pkg::CTRL_OTG_PIN_ENABLE];
        otg_pin_polarity_ff <= i_avs_writedata[cbm_pkg::CTRL_OTG_POL];
      end else begin
        if (chg_expire) begin
          charge_disable_bit_ff <= 1'b1;
        end
        if (boost_fault) begin
          boost_select_bit_ff <= 1'b0;
        end
      end
    end
  end

  // Host watchdog: cleared by kick, high-z entry or reset; frozen by the pin.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wdog_cnt_ff <= 64'h0;
    end else if (i_ce) begin
      if (sw_reset || wdog_expire ||
          (wr_ctrl && (i_avs_writedata[cbm_pkg::CTRL_KICK] ||
                       i_avs_writedata[cbm_pkg::CTRL_HIGHZ] ||
                       i_avs_writedata[cbm_pkg::CTRL_CHG_DIS]))) begin
        wdog_cnt_ff <= 64'h0;
      end else if (dis_pin) begin
        wdog_cnt_ff <= wdog_cnt_ff;
      end else if (boost_on ||
                   ((high_z_request_ff || charge_disable_bit_ff) && an.weak_batt)) begin
        wdog_cnt_ff <= wdog_cnt_ff + 64'h1;
      end
    end
  end

  // Standalone charge timer, armed when the watchdog restores defaults outside boost.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      timed_charge_ff <= 1'b0;
      chg_cnt_ff <= 64'h0;
      dis_pin_d_ff <= 1'b0;
    end else if (i_ce) begin
      dis_pin_d_ff <= dis_pin;
      if (wr_ctrl || por || chg_expire) begin
        timed_charge_ff <= wdog_expire & ~boost_on & ~wr_ctrl;
        chg_cnt_ff <= 64'h0;
      end else if (wdog_expire && !boost_on) begin
        timed_charge_ff <= 1'b1;
        chg_cnt_ff <= 64'h0;
      end else if (timed_charge_ff && dis_pin && !dis_pin_d_ff) begin
        chg_cnt_ff <= 64'h0;
      end else if (timed_charge_ff && charging) begin
        chg_cnt_ff <= chg_cnt_ff + 64'h1;
      end
    end
  end

  // Fault code: set wins over a read clear.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fault_code_ff <= cbm_pkg::FAULT_RESET_VAL;
      fault_active_ff <= 1'b0;
    end else if (i_ce) begin
      if (boost_fault) begin
        fault_code_ff <= nxt_fault;
        fault_active_ff <= 1'b1;
      end else if (rd_status || por) begin
        fault_code_ff <= cbm_pkg::FLT_NONE;
        fault_active_ff <= 1'b0;
      end
    end
  end

  // Status pulse.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pulse_cnt_ff <= 32'h0;
    end else if (i_ce) begin
      if (boost_fault) begin
        pulse_cnt_ff <= cbm_pkg::PULSE_CYC;
      end else if (pulse_cnt_ff != 32'h0) begin
        pulse_cnt_ff <= pulse_cnt_ff - 32'h1;
      end
    end
  end

  // Boost start-up sequencer.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_ff <= ST_OFF;
      seq_cnt_ff <= 32'h0;
      half_done_ff <= 1'b0;
      otg_started_ff <= 1'b0;
      retried_ff <= 1'b0;
    end else if (i_ce) begin
      seq_cnt_ff <= seq_cnt_ff + 32'h1;
      if (boost_fault) begin
        state_ff <= ST_FAULT_WAIT;
        seq_cnt_ff <= 32'h0;
      end else begin
        unique case (state_ff)
          ST_OFF: begin
            retried_ff <= 1'b0;
            seq_cnt_ff <= 32'h0;
            if (boost_req && an.batt_above_uvlo) begin
              state_ff <= ST_PRECHARGE;
              otg_started_ff <= otg_pin_enable_ff & otg_active;
            end
          end
          ST_PRECHARGE: begin
            if (!boost_req) begin
              state_ff <= ST_OFF;
            end else if (an.mid_ok) begin
              state_ff <= ST_SOFTSTART;
              seq_cnt_ff <= 32'h0;
              half_done_ff <= 1'b0;
            end
          end
          ST_SOFTSTART: begin
            if (!boost_req) begin
              state_ff <= ST_OFF;
            end else if (an.near_setpoint) begin
              state_ff <= ST_REGULATE;
            end else if (!half_done_ff && seq_cnt_ff >= SS_HALF_CYC - 1) begin
              half_done_ff <= 1'b1;
              seq_cnt_ff <= 32'h0;
            end
          end
          ST_REGULATE: begin
            if (!boost_req) begin
              state_ff <= ST_OFF;
            end
          end
          ST_FAULT_WAIT: begin
            if (!(otg_pin_enable_ff && otg_active)) begin
              state_ff <= ST_OFF;
            end else if (seq_cnt_ff >= (retried_ff ? RESTART_NEXT_CYC : RESTART_FIRST_CYC) - 1)
            begin
              state_ff <= ST_PRECHARGE;
              retried_ff <= 1'b1;
              seq_cnt_ff <= 32'h0;
            end
          end
        endcase
      end
    end
  end

  // Regulate-state current limit, pulse skipping and on-time stretch.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ilim_cnt_ff <= 32'h0;
      skip_ff <= 1'b0;
      long_on_ff <= 1'b0;
    end else if (i_ce) begin
      ilim_cnt_ff <= (state_ff == ST_REGULATE && an.ilim) ? ilim_cnt_ff + 32'h1 : 32'h0;
      if (state_ff != ST_REGULATE) begin
        skip_ff <= 1'b0;
        long_on_ff <= 1'b0;
      end else if (an.min_off_done) begin
        skip_ff <= an.fb_above_ref;
        long_on_ff <= an.zero_current | an.fb_above_ref;
      end else if (skip_ff && !an.fb_above_ref) begin
        skip_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_charge_en <= 1'b0;
      o_status_pulse <= 1'b0;
      o_mode <= cbm_pkg::MODE_CHARGE;
      o_boost_ctl <= '0;
    end else if (i_ce) begin
      o_charge_en <= charging;
      o_status_pulse <= (pulse_cnt_ff != 32'h0);
      if (high_z_request_ff || hz_hold_ff) begin
        o_mode <= cbm_pkg::MODE_HIGHZ;
      end else if (fault_active_ff) begin
        o_mode <= cbm_pkg::MODE_CHG_CFG;
      end else if (boost_select_bit_ff) begin
        o_mode <= cbm_pkg::MODE_BOOST;
      end else begin
        o_mode <= cbm_pkg::MODE_CHARGE;
      end
      o_boost_ctl.current_src_on <= (state_ff == ST_PRECHARGE);
      o_boost_ctl.switching <= (state_ff == ST_SOFTSTART) || (state_ff == ST_REGULATE);
      o_boost_ctl.half_limit <= (state_ff == ST_SOFTSTART) && !half_done_ff;
      o_boost_ctl.loop_closed <= (state_ff == ST_REGULATE);
      o_boost_ctl.switch_inhibit <= (state_ff == ST_REGULATE) &&
                                    (an.fb_above_ref || skip_ff);
      o_boost_ctl.long_on_time <= long_on_ff;
      o_boost_ctl.pulse_skip <= skip_ff && (state_ff == ST_REGULATE);
      o_boost_ctl.stage_highz <= !boost_on;
    end
  end
endmodule

/* src/cbm_pkg.sv */
// Package of constants and types for the charger and boost mode controller.
// Assumes a 50 MHz system clock; every count is derived from that rate.
package cbm_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  // Times in their own units.
  localparam int unsigned WDOG_S = 32;
  localparam int unsigned CHG_TMR_S = 900;
  localparam int unsigned LIN_TMO_NS = 560000;
  localparam int unsigned SS_HALF_NS = 128000;
  localparam int unsigned SS_FULL_NS = 384000;
  localparam int unsigned ILIM_NS = 50000;
  localparam int unsigned RESTART_FIRST_NS = 5200000;
  localparam int unsigned RESTART_NEXT_NS = 5000000;
  localparam int unsigned PULSE_NS = 128000;
  // Cycle counts, least times rounded up, longest rounded down.
  localparam longint unsigned WDOG_CYC = longint'(WDOG_S) * CLK_HZ;
  localparam longint unsigned CHG_TMR_CYC = longint'(CHG_TMR_S) * CLK_HZ;
  localparam int unsigned LIN_TMO_CYC = (LIN_TMO_NS * 50 + 999) / 1000;
  localparam int unsigned SS_HALF_CYC = (SS_HALF_NS * 50 + 999) / 1000;
  localparam int unsigned SS_FULL_CYC = (SS_FULL_NS * 50 + 999) / 1000;
  localparam int unsigned ILIM_CYC = (ILIM_NS * 50 + 999) / 1000;
  localparam int unsigned RESTART_FIRST_CYC = (RESTART_FIRST_NS / 1000) * 50;
  localparam int unsigned RESTART_NEXT_CYC = (RESTART_NEXT_NS / 1000) * 50;
  localparam int unsigned PULSE_CYC = (PULSE_NS * 50 + 999) / 1000;
  // Register offsets on the Avalon word bus.
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_CTRL = 4'h1;
  localparam logic [3:0] OFS_MODE = 4'h2;
  // Control register field positions.
  localparam int CTRL_BOOST_SEL = 0;
  localparam int CTRL_HIGHZ = 1;
  localparam int CTRL_CHG_DIS = 2;
  localparam int CTRL_OTG_PIN_ENABLE = 3;
  localparam int CTRL_OTG_POL = 4;
  localparam int CTRL_KICK = 5;
  localparam int CTRL_RESET = 6;
  localparam logic [7:0] CTRL_RESET_VAL = 8'h00;
  localparam logic [2:0] FAULT_RESET_VAL = 3'h0;
  // Boost fault codes.
  localparam logic [2:0] FLT_NONE = 3'h0;
  localparam logic [2:0] FLT_OVP = 3'h1;
  localparam logic [2:0] FLT_START = 3'h2;
  localparam logic [2:0] FLT_UVLO = 3'h3;
  localparam logic [2:0] FLT_THERM = 3'h5;
  localparam logic [2:0] FLT_TIMER = 3'h6;

  typedef enum logic [1:0] {
    MODE_CHARGE,
    MODE_CHG_CFG,
    MODE_BOOST,
    MODE_HIGHZ
  } cbm_mode_t;

  typedef struct packed {
    logic weak_batt;
    logic mid_ok;
    logic boost_good;
    logic near_setpoint;
    logic ovp;
    logic batt_above_uvlo;
    logic thermal;
    logic fb_above_ref;
    logic ilim;
    logic min_off_done;
    logic zero_current;
  } cbm_analog_t;

  typedef struct packed {
    logic current_src_on;
    logic switching;
    logic half_limit;
    logic loop_closed;
    logic switch_inhibit;
    logic long_on_time;
    logic pulse_skip;
    logic stage_highz;
  } cbm_boost_ctl_t;
endpackage

/* testbench/cbm_monitor.sv */
// Checker of the mode controller's port behaviour.
// Assumes it is bound to cbm_mode_ctrl with the same timing parameters.
`timescale 1ns/10ps
module cbm_monitor #(
  parameter int unsigned LIN_TMO_CYC = 20,
  parameter int unsigned SS_HALF_CYC = 10
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic o_status_pulse,
  input wire cbm_pkg::cbm_boost_ctl_t o_boost_ctl
);
  int unsigned lin_ff;
  int unsigned half_ff;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Counts how long precharge and the half limit last.
  always_ff @(posedge i_clk) begin
    lin_ff <= (i_rst || !o_boost_ctl.current_src_on) ? 0 : lin_ff + 1;
  end
  always_ff @(posedge i_clk) begin
    half_ff <= (i_rst || !o_boost_ctl.half_limit) ? 0 : half_ff + 1;
  end

  sequence s_req_start;
    $rose(i_avs_read || i_avs_write);
  endsequence
  sequence s_pulse_hold;
    o_status_pulse [*8];
  endsequence

  property p_bus_wait;
    s_req_start |-> o_avs_waitrequest ##1 !o_avs_waitrequest;
  endproperty
  property p_src_excl;
    o_boost_ctl.current_src_on |-> !o_boost_ctl.switching;
  endproperty
  property p_lin_limit;
    lin_ff <= LIN_TMO_CYC + 2;
  endproperty
  property p_half_sw;
    o_boost_ctl.half_limit |-> o_boost_ctl.switching && !o_boost_ctl.loop_closed;
  endproperty
  property p_half_limit;
    half_ff <= SS_HALF_CYC + 2;
  endproperty
  property p_inhibit;
    o_boost_ctl.switch_inhibit |-> o_boost_ctl.loop_closed;
  endproperty
  property p_skip;
    o_boost_ctl.pulse_skip |-> o_boost_ctl.long_on_time && o_boost_ctl.loop_closed;
  endproperty
  property p_highz;
    o_boost_ctl.stage_highz |-> !o_boost_ctl.switching && !o_boost_ctl.current_src_on;
  endproperty
  property p_pulse;
    $rose(o_status_pulse) |-> s_pulse_hold;
  endproperty

  a_bus_wait: assert property (p_bus_wait) else $error("bus wait cycle wrong");
  a_src_excl: assert property (p_src_excl) else $error("source on while switching");
  a_lin_limit: assert property (p_lin_limit) else $error("precharge too long");
  a_half_sw: assert property (p_half_sw) else $error("half limit outside soft-start");
  a_half_limit: assert property (p_half_limit) else $error("half limit too long");
  a_inhibit: assert property (p_inhibit) else $error("inhibit outside regulation");
  a_skip: assert property (p_skip) else $error("skip without long on-time");
  a_highz: assert property (p_highz) else $error("stage active while high-z");
  a_pulse: assert property (p_pulse) else $error("status pulse too short");
endmodule

/* testbench/cbm_analog_model.sv */
// Model of the boost power stage and its comparators.
// Assumes the bench drives i_env at clock edges; a delay of 8'hff means never.
`timescale 1ns/10ps
module cbm_analog_model (
  input wire logic i_clk,
  input wire cbm_pkg::cbm_boost_ctl_t i_ctl,
  input wire cbm_pkg::cbm_analog_t i_env,
  input wire logic [7:0] i_mid_dly,
  input wire logic [7:0] i_good_dly,
  output cbm_pkg::cbm_analog_t o_analog
);
  logic [7:0] pre_ff;
  logic [7:0] sw_ff;
  logic [2:0] rnd_ff;

  // Mid rail and output rise only while the stage drives them.
  always_ff @(posedge i_clk) begin
    pre_ff <= !i_ctl.current_src_on ? 8'h0 : (pre_ff == 8'hfe) ? pre_ff : pre_ff + 8'h1;
    sw_ff <= !i_ctl.switching ? 8'h0 : (sw_ff == 8'hfe) ? sw_ff : sw_ff + 8'h1;
    rnd_ff <= 3'($urandom);
  end

  always_comb begin
    o_analog = i_env;
    o_analog.mid_ok = i_ctl.switching || (i_mid_dly != 8'hff && pre_ff >= i_mid_dly);
    o_analog.boost_good = i_good_dly != 8'hff && sw_ff >= i_good_dly;
    o_analog.near_setpoint = o_analog.boost_good;
    if (i_ctl.loop_closed) begin
      o_analog.fb_above_ref = rnd_ff[0];
      o_analog.min_off_done = rnd_ff[1];
      o_analog.zero_current = rnd_ff[2];
    end
  end
endmodule

/* testbench/cbm_mode_ctrl_test.sv */
// Self-checking bench for the charger and boost mode controller.
// Assumes shortened timing parameters and an Avalon master built from tasks.
`timescale 1ns/10ps
module cbm_mode_ctrl_test;
  localparam int WD = 200;
  localparam int RF = 60;
  localparam int RN = 50;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wait_req;
  logic dis_pin = 1'b0;
  logic otg_pin = 1'b0;
  logic por = 1'b0;
  logic chg_en;
  logic pulse;
  cbm_pkg::cbm_mode_t mode;
  cbm_pkg::cbm_boost_ctl_t bctl;
  cbm_pkg::cbm_analog_t env = '0;
  cbm_pkg::cbm_analog_t ana;
  logic [7:0] mid_dly = 8'h4;
  logic [7:0] good_dly = 8'h4;
  logic [2:0] codes [3] = '{cbm_pkg::FLT_OVP, cbm_pkg::FLT_UVLO, cbm_pkg::FLT_THERM};
  logic [2:0] b;
  logic [31:0] d;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int n;

  cbm_mode_ctrl #(.WDOG_CYC(WD), .CHG_TMR_CYC(400), .RESTART_FIRST_CYC(RF),
    .RESTART_NEXT_CYC(RN), .LIN_TMO_CYC(20), .SS_HALF_CYC(10), .SS_FULL_CYC(30)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_avs_address(adr), .i_avs_read(rd_en),
    .i_avs_write(wr_en), .i_avs_writedata(wdat), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wait_req), .i_disable_pin(dis_pin), .i_otg_pin(otg_pin),
    .i_bus_por(por), .i_analog(ana), .o_charge_en(chg_en), .o_status_pulse(pulse),
    .o_mode(mode), .o_boost_ctl(bctl));
  cbm_analog_model u_ana (.i_clk(i_clk), .i_ctl(bctl), .i_env(env), .i_mid_dly(mid_dly),
    .i_good_dly(good_dly), .o_analog(ana));

  initial begin
    forever #10 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clk);
    adr <= a;
    wdat <= v;
    rd_en <= !w;
    wr_en <= w;
    do @(posedge i_clk); while (wait_req !== 1'b0);
    d = rdat;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge i_clk);
    i_rst <= 1'b1;
    env <= '{batt_above_uvlo: 1'b1, default: 1'b0};
    mid_dly <= 8'h4;
    good_dly <= 8'h4;
    otg_pin <= 1'b0;
    dis_pin <= 1'b0;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
  endtask

  task automatic wait_state(input logic [2:0] st);
    for (int i = 0; i < 80; i++) begin
      bus(1'b0, cbm_pkg::OFS_MODE, 32'h0);
      if (d[5:3] == st) break;
    end
  endtask

  task automatic wait_pulse();
    for (int i = 0; i < 300 && pulse !== 1'b1; i++) @(posedge i_clk);
  endtask

  function automatic logic chg_exp(input logic pin, input logic dis, input logic hz);
    return !(pin || dis || hz);
  endfunction

  function automatic cbm_pkg::cbm_mode_t mode_exp(input logic hz, input logic flt);
    if (hz) return cbm_pkg::MODE_HIGHZ;
    return flt ? cbm_pkg::MODE_CHG_CFG : cbm_pkg::MODE_CHARGE;
  endfunction

  initial begin
    void'($urandom(32'hd0d2));
    do_reset();
    repeat (6) @(posedge i_clk);
    bus(1'b0, cbm_pkg::OFS_CTRL, 32'h0);
    check("ctrl_reset", d, 32'h0);
    bus(1'b0, cbm_pkg::OFS_STATUS, 32'h0);
    check("status_reset", d, 32'h0);
    bus(1'b1, 4'hf, 32'hff);
    bus(1'b0, 4'hf, 32'h0);
    check("unmapped", d, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      b = 3'($urandom);
      dis_pin <= b[2];
      bus(1'b1, cbm_pkg::OFS_CTRL, {29'h0, b[1], b[0], 1'b0});
      repeat (6) @(posedge i_clk);
      check("charge_en", chg_en, chg_exp(b[2], b[1], b[0]));
      check("mode", mode, mode_exp(b[0], 1'b0));
      bus(1'b0, cbm_pkg::OFS_CTRL, 32'h0);
      check("ctrl_rd", d[2:0], {b[1], b[0], 1'b0});
    end
    bus(1'b1, cbm_pkg::OFS_CTRL, 32'h6);
    bus(1'b1, cbm_pkg::OFS_CTRL, 32'h40);
    bus(1'b0, cbm_pkg::OFS_CTRL, 32'h0);
    check("reset_bit", d, 32'h0);
    check("reset_hold", mode, cbm_pkg::MODE_HIGHZ);
    do_reset();
    env.weak_batt <= 1'b1;
    bus(1'b1, cbm_pkg::OFS_CTRL, 32'h1a);
    repeat (WD + 20) @(posedge i_clk);
    bus(1'b0, cbm_pkg::OFS_CTRL, 32'h0);
    check("wdog_default", d, 32'h0);
    $display("test charge control done");
    do_reset();
    bus(1'b1, cbm_pkg::OFS_CTRL, 32'h1);
    wait_state(3'h3);
    check("regulate", d[5:3], 3'h3);
    for (int i = 0; i < 3; i++) begin
      repeat (WD / 2) @(posedge i_clk);
      bus(1'b1, cbm_pkg::OFS_CTRL, 32'h21);
    end
    check("boost_kept", mode, cbm_pkg::MODE_BOOST);
    wait_pulse();
    bus(1'b0, cbm_pkg::OFS_STATUS, 32'h0);
    check("timer_fault", d, 32'he);
    bus(1'b0, cbm_pkg::OFS_CTRL, 32'h0);
    check("timer_ctrl", d, 32'h0);
    bus(1'b0, cbm_pkg::OFS_STATUS, 32'h0);
    check("fault_clear", d, 32'h0);
    for (int k = 0; k < 3; k++) begin
      do_reset();
      bus(1'b1, cbm_pkg::OFS_CTRL, 32'h1);
      wait_state(3'h3);
      env <= '{ovp: k == 0, batt_above_uvlo: k != 1, thermal: k == 2, default: 1'b0};
      wait_pulse();
      repeat (4) @(posedge i_clk);
      check("stage_highz", bctl.stage_highz, 1'b1);
      check("mode_cfg", mode, mode_exp(1'b0, 1'b1));
      bus(1'b0, cbm_pkg::OFS_STATUS, 32'h0);
      check("fault_code", d, {28'h0, 1'b1, codes[k]});
      bus(1'b0, cbm_pkg::OFS_CTRL, 32'h0);
      check("select_clear", d[0], 1'b0);
    end
    for (int j = 0; j < 2; j++) begin
      do_reset();
      mid_dly <= j ? 8'h4 : 8'hff;
      good_dly <= j ? 8'hff : 8'h4;
      bus(1'b1, cbm_pkg::OFS_CTRL, 32'h1);
      wait_pulse();
      bus(1'b0, cbm_pkg::OFS_STATUS, 32'h0);
      check("start_fault", d, 32'ha);
      repeat (RF + 20) @(posedge i_clk);
      bus(1'b0, cbm_pkg::OFS_MODE, 32'h0);
      check("stay_off", d[5:3], 3'h0);
    end
    $display("test boost faults done");
    for (int p = 0; p < 2; p++) begin
      do_reset();
      mid_dly <= 8'hff;
      otg_pin <= p[0];
      bus(1'b1, cbm_pkg::OFS_CTRL, {27'h0, p[0], 2'h2, p[0], 1'b0});
      for (int g = 0; g < 2; g++) begin
        for (n = 0; n < 300 && !bctl.current_src_on; n++) @(posedge i_clk);
        for (n = 0; n < 300 && bctl.current_src_on; n++) @(posedge i_clk);
        for (n = 0; n < 300 && !bctl.current_src_on; n++) @(posedge i_clk);
        check("restart_gap", (n >= (g ? RN : RF) - 3) && (n <= (g ? RN : RF) + 3), 1'b1);
      end
      otg_pin <= !p[0];
      repeat (RF + 10) @(posedge i_clk);
      n = 0;
      repeat (RF + RN) begin
        @(posedge i_clk);
        n += bctl.current_src_on;
      end
      check("pin_inactive", n, 0);
      por <= 1'b1;
      repeat (4) @(posedge i_clk);
      por <= 1'b0;
      bus(1'b0, cbm_pkg::OFS_STATUS, 32'h0);
      check("por_clear", d, 32'h0);
    end
    $display("test restart done");
    tally_and_finish();
  end
endmodule

bind cbm_mode_ctrl cbm_monitor #(.LIN_TMO_CYC(LIN_TMO_CYC), .SS_HALF_CYC(SS_HALF_CYC)) u_mon (
  .i_clk(i_clk), .i_rst(i_rst), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest), .o_status_pulse(o_status_pulse),
  .o_boost_ctl(o_boost_ctl));
